// File: smsp_params.svh
`ifndef SMSP_PARAMS_SVH
`define SMSP_PARAMS_SVH

// Reference clock and timebase
`define SMSP_REF_CLK_HZ        10000000
`define SMSP_POLL_TOGGLE_HZ    1000
`define SMSP_TOGGLE_HALF_CYC   (`SMSP_REF_CLK_HZ / (2 * `SMSP_POLL_TOGGLE_HZ))
`define SMSP_TOGGLE_CNT_W      16

// Command codes
`define SMSP_CMD_WRITE_CFG     8'h01
`define SMSP_CMD_READ_CFG      8'h02
`define SMSP_CMD_POLL_CONV     8'h40
`define SMSP_CMD_POLL_INT      8'h50

// Upper nibbles of the conversion-start command families
`define SMSP_START_CELL        4'h1
`define SMSP_START_OPEN        4'h2
`define SMSP_START_TEMP        4'h3
`define SMSP_START_CELL_DIS    4'h6
`define SMSP_START_OPEN_DIS    4'h7

// Configuration group layout, byte 0 in the top bits
`define SMSP_CFG_BITS          48
`define SMSP_CFG_DEFAULT       48'h0000_0000_0000
`define SMSP_CFG_CDC_MSB       42
`define SMSP_CFG_CDC_LSB       40
`define SMSP_CFG_CELL10_BIT    43
`define SMSP_CFG_LEVEL_BIT     44
`define SMSP_CFG_UV_MSB        15
`define SMSP_CFG_UV_LSB        8
`define SMSP_CFG_OV_MSB        7
`define SMSP_CFG_OV_LSB        0
`define SMSP_READ_BITS         56

// Monitor mode settings
`define SMSP_CDC_MONITOR       3'h5
`define SMSP_FACTORY_UV        8'h00
`define SMSP_FACTORY_OV        8'hFF
`define SMSP_BASE_CELLS        4'h5

// Error code
`define SMSP_CRC_POLY          8'h07
`define SMSP_CRC_INIT          8'h00

// Host register offsets and fields
`define SMSP_REG_XFER          4'h0
`define SMSP_REG_RXDATA        4'h4
`define SMSP_REG_STATUS        4'h8
`define SMSP_REG_RELEASE       4'hC
`define SMSP_XFER_KEEP_BIT     8
`define SMSP_HOST_SCLK_HALF    4

`endif

// File: smsp_pkg.sv
`include "smsp_params.svh"

package smsp_pkg;

  typedef enum logic [5:0] {
    DEV_IDLE    = 6'h01,
    DEV_CMD     = 6'h02,
    DEV_WRITE   = 6'h04,
    DEV_READ    = 6'h08,
    DEV_POLL    = 6'h10,
    DEV_MONITOR = 6'h20
  } smsp_dev_state_e;

  typedef enum logic [3:0] {
    HOST_IDLE = 4'h1,
    HOST_LEAD = 4'h2,
    HOST_LOW  = 4'h4,
    HOST_HIGH = 4'h8
  } smsp_host_state_e;

  typedef struct packed {
    smsp_dev_state_e                state;
    logic [2:0]                     sclk_sy;
    logic [2:0]                     cs_sy;
    logic [1:0]                     mosi_sy;
    logic [1:0]                     hs_sy;
    logic [2:0]                     strap_s1;
    logic [2:0]                     strap_s2;
    logic [2:0]                     pin_s1;
    logic [2:0]                     pin_s2;
    logic                           mm_prev;
    logic [2:0]                     bitcnt;
    logic [7:0]                     cmd_sh;
    logic [`SMSP_CFG_BITS-1:0]      wr_sh;
    logic [5:0]                     wr_cnt;
    logic [`SMSP_READ_BITS-1:0]     rd_sh;
    logic [`SMSP_CFG_BITS-1:0]      cfg;
    logic                           low_bit;
    logic                           hs_bit;
    logic                           cs_out;
    logic                           sclk_out;
    logic                           poll_int;
    logic [`SMSP_TOGGLE_CNT_W-1:0]  tog_cnt;
    logic                           tog;
    logic                           start;
  } smsp_dev_s;

  typedef struct packed {
    smsp_host_state_e  state;
    logic [7:0]        cnt;
    logic [2:0]        bitn;
    logic [7:0]        tx;
    logic [7:0]        rx;
    logic              keep;
    logic              cs_n;
    logic              sclk;
    logic              mosi;
    logic [1:0]        miso_sy;
    logic              ack;
    logic [31:0]       rdata;
  } smsp_host_s;

endpackage

// File: smsp_if.sv
// Low side port of the bottom device, facing the controller
interface smsp_if;
  logic chip_select_in_n;
  logic serial_clock_in;
  logic low_side_data;
  logic lsd_o;
  logic lsd_oe;
  logic bottom_data_out;
  logic bottom_data_out_oe;
  logic miso;

  // Pulled-up read line: open-drain output and driven data pin wired together
  assign miso = (bottom_data_out_oe ? bottom_data_out : 1'b1) & (lsd_oe ? lsd_o : 1'b1);

  modport host (
    output chip_select_in_n,
    output serial_clock_in,
    output low_side_data,
    input  miso
  );

  modport dev (
    input  chip_select_in_n,
    input  serial_clock_in,
    input  low_side_data,
    output lsd_o,
    output lsd_oe,
    output bottom_data_out,
    output bottom_data_out_oe
  );
endinterface

// File: smsp_host.sv
`include "smsp_params.svh"

module smsp_host #(
  parameter int SCLK_HALF = `SMSP_HOST_SCLK_HALF
) (
  // Clock and reset
  input  wire logic        i_ref_clk,
  input  wire logic        i_nrst,
  // Wishbone classic slave
  input  wire logic        i_wb_cyc,
  input  wire logic        i_wb_stb,
  input  wire logic        i_wb_we,
  input  wire logic [3:0]  i_wb_adr,
  input  wire logic [31:0] i_wb_dat,
  input  wire logic [3:0]  i_wb_sel,
  output logic      [31:0] o_wb_dat,
  output logic             o_wb_ack,
  // Serial link
  smsp_if.host             link
);

  smsp_pkg::smsp_host_s r;
  smsp_pkg::smsp_host_s n;
  logic                 req;
  logic                 half_done;

  // Bus request seen once; ack drops the cycle after it was given
  assign req       = i_wb_cyc & i_wb_stb & ~r.ack;
  assign half_done = (r.cnt == 8'(SCLK_HALF - 1));

  // Next state
  always_comb begin
    n = r;
    n.miso_sy = {r.miso_sy[0], link.miso};
    n.ack = req;
    n.cnt = half_done ? 8'h00 : r.cnt + 8'h01;
    if (req && !i_wb_we) begin
      unique case (i_wb_adr)
        `SMSP_REG_RXDATA: n.rdata = {24'h00_0000, r.rx};
        `SMSP_REG_STATUS: n.rdata = {29'h0000_0000, r.miso_sy[1], ~r.cs_n,
                                     (r.state != smsp_pkg::HOST_IDLE)};
        default:          n.rdata = 32'h0000_0000;
      endcase
    end
    unique case (r.state)
      smsp_pkg::HOST_IDLE: begin
        n.cnt = 8'h00;
        if (req && i_wb_we && i_wb_sel[0] && i_wb_adr == `SMSP_REG_XFER) begin
          n.tx    = i_wb_dat[7:0];
          n.keep  = i_wb_dat[`SMSP_XFER_KEEP_BIT];
          n.cs_n  = 1'b0;
          n.bitn  = 3'h0;
          n.state = smsp_pkg::HOST_LEAD;
        end else if (req && i_wb_we && i_wb_adr == `SMSP_REG_RELEASE) begin
          n.cs_n = 1'b1;
        end
      end
      smsp_pkg::HOST_LEAD: begin
        if (half_done) begin
          n.sclk  = 1'b0;
          n.mosi  = r.tx[7];
          n.state = smsp_pkg::HOST_LOW;
        end
      end
      smsp_pkg::HOST_LOW: begin
        if (half_done) begin
          n.sclk  = 1'b1;
          n.state = smsp_pkg::HOST_HIGH;
        end
      end
      smsp_pkg::HOST_HIGH: begin
        // Sample at the end of the high phase: the slave updates after its falling edge
        if (half_done) begin
          n.rx = {r.rx[6:0], r.miso_sy[1]};
          n.tx = {r.tx[6:0], 1'b0};
          if (r.bitn == 3'h7) begin
            n.cs_n  = ~r.keep;
            n.state = smsp_pkg::HOST_IDLE;
          end else begin
            n.bitn  = r.bitn + 3'h1;
            n.sclk  = 1'b0;
            n.mosi  = r.tx[6];
            n.state = smsp_pkg::HOST_LOW;
          end
        end
      end
    endcase
  end

  // State register
  always_ff @(posedge i_ref_clk) begin
    if (!i_nrst) begin
      r         <= '0;
      r.state   <= smsp_pkg::HOST_IDLE;
      r.cs_n    <= 1'b1;
      r.sclk    <= 1'b1;
      r.mosi    <= 1'b1;
      r.miso_sy <= 2'h3;
    end else begin
      r <= n;
    end
  end

  // Outputs
  assign o_wb_dat              = r.rdata;
  assign o_wb_ack              = r.ack;
  assign link.chip_select_in_n = r.cs_n;
  assign link.serial_clock_in  = r.sclk;
  assign link.low_side_data    = r.mosi;

endmodule

// File: smsp_device.sv
`include "smsp_params.svh"

module smsp_device #(
  parameter int TOGGLE_HALF = `SMSP_TOGGLE_HALF_CYC
) (
  // Clock and reset
  input  wire logic                      i_ref_clk,
  input  wire logic                      i_nrst,
  // Low side port
  smsp_if.dev                            link,
  // High side port
  input  wire logic                      i_high_side_data,
  output logic                           o_high_side_data,
  output logic                           o_high_side_data_oe,
  output logic                           o_chip_select_out_n,
  output logic                           o_serial_clock_out,
  // Straps and cell-count pins
  input  wire logic                      i_monitor_mode_strap_n,
  input  wire logic                      i_voltage_signalling_strap,
  input  wire logic                      i_top_of_stack_strap,
  input  wire logic                      i_watchdog_pin_n,
  input  wire logic                      i_gp_pin_two,
  input  wire logic                      i_gp_pin_one,
  // Converter status
  input  wire logic                      i_conv_busy,
  input  wire logic                      i_cell_alarm,
  output logic                           o_start_conv,
  // Effective configuration
  output logic [`SMSP_CFG_BITS-1:0]      o_cfg,
  output logic [2:0]                     o_comparator_duty_cycle,
  output logic [7:0]                     o_undervoltage_threshold,
  output logic [7:0]                     o_overvoltage_threshold,
  output logic                           o_level_poll_select,
  output logic [3:0]                     o_cell_count,
  output logic                           o_monitor_mode,
  output logic                           o_current_mode
);

  smsp_pkg::smsp_dev_s r;
  smsp_pkg::smsp_dev_s n;
  logic                sclk_rise;
  logic                sclk_fall;
  logic                cs_rise;
  logic                cs_fall;
  logic                mm_low;
  logic                mm_rise;
  logic                bottom;
  logic                top;
  logic                level_sel;
  logic                drive_low;
  logic                poll_val;
  logic [7:0]          cmd_byte;

  // CRC-8 over the group, first bit in read order first
  function automatic logic [7:0] crc8(input logic [`SMSP_CFG_BITS-1:0] d);
    logic [7:0] c;
    logic       fb;
    c = `SMSP_CRC_INIT;
    for (int i = `SMSP_CFG_BITS - 1; i >= 0; i--) begin
      fb = c[7] ^ d[i];
      c  = {c[6:0], 1'b0} ^ (fb ? `SMSP_CRC_POLY : 8'h00);
    end
    return c;
  endfunction

  // Edges from the second and third synchroniser stages only
  assign sclk_rise = r.sclk_sy[1] & ~r.sclk_sy[2];
  assign sclk_fall = ~r.sclk_sy[1] & r.sclk_sy[2];
  assign cs_rise   = r.cs_sy[1] & ~r.cs_sy[2];
  assign cs_fall   = ~r.cs_sy[1] & r.cs_sy[2];
  assign mm_low    = ~r.strap_s2[2];
  assign mm_rise   = r.strap_s2[2] & ~r.mm_prev;
  assign bottom    = r.strap_s2[1];
  assign top       = r.strap_s2[0];
  assign level_sel = r.cfg[`SMSP_CFG_LEVEL_BIT];
  assign cmd_byte  = {r.cmd_sh[6:0], r.mosi_sy[1]};

  // Poll answer: busy, or the cell alarm for interrupt polls, holds low, else pass the higher device or originate at the top
  always_comb begin
    poll_val = 1'b0;
    if (!(r.poll_int ? i_cell_alarm : i_conv_busy)) begin
      if (!top) begin
        poll_val = r.hs_sy[1];
      end else begin
        poll_val = level_sel ? 1'b1 : r.tog;
      end
    end
  end

  // Next state
  always_comb begin
    n          = r;
    n.start    = 1'b0;
    n.sclk_sy  = {r.sclk_sy[1:0], link.serial_clock_in};
    n.cs_sy    = {r.cs_sy[1:0], link.chip_select_in_n};
    n.mosi_sy  = {r.mosi_sy[0], link.low_side_data};
    n.hs_sy    = {r.hs_sy[0], i_high_side_data};
    n.strap_s1 = {i_monitor_mode_strap_n, i_voltage_signalling_strap, i_top_of_stack_strap};
    n.strap_s2 = r.strap_s1;
    n.pin_s1   = {i_watchdog_pin_n, i_gp_pin_two, i_gp_pin_one};
    n.pin_s2   = r.pin_s1;
    n.mm_prev  = r.strap_s2[2];
    // Forwarded select and clock share one register delay with forwarded data
    n.cs_out   = r.cs_sy[1];
    n.sclk_out = r.sclk_sy[1];
    // Free-running square wave, unrelated to the serial clock
    if (r.tog_cnt == `SMSP_TOGGLE_CNT_W'(TOGGLE_HALF - 1)) begin
      n.tog_cnt = '0;
      n.tog     = ~r.tog;
    end else begin
      n.tog_cnt = r.tog_cnt + `SMSP_TOGGLE_CNT_W'(1);
    end
    unique case (r.state)
      smsp_pkg::DEV_IDLE: begin
        if (cs_fall) begin
          n.bitcnt = 3'h0;
          n.state  = smsp_pkg::DEV_CMD;
        end
      end
      smsp_pkg::DEV_CMD: begin
        // Command bits pass straight up so every device decodes the same byte
        n.hs_bit = r.mosi_sy[1];
        if (sclk_rise) begin
          n.cmd_sh = cmd_byte;
          n.bitcnt = r.bitcnt + 3'h1;
          if (r.bitcnt == 3'h7) begin
            n.state = smsp_pkg::DEV_IDLE;
            if (cmd_byte == `SMSP_CMD_WRITE_CFG) begin
              n.wr_cnt = 6'h00;
              n.state  = smsp_pkg::DEV_WRITE;
            end else if (cmd_byte == `SMSP_CMD_READ_CFG) begin
              n.rd_sh   = {r.cfg, crc8(r.cfg)};
              n.low_bit = r.cfg[`SMSP_CFG_BITS-1];
              n.state   = smsp_pkg::DEV_READ;
            end else if (cmd_byte == `SMSP_CMD_POLL_CONV) begin
              n.poll_int = 1'b0;
              n.state    = smsp_pkg::DEV_POLL;
            end else if (cmd_byte == `SMSP_CMD_POLL_INT) begin
              n.poll_int = 1'b1;
              n.state    = smsp_pkg::DEV_POLL;
            end else if (cmd_byte[7:4] == `SMSP_START_CELL ||
                         cmd_byte[7:4] == `SMSP_START_OPEN ||
                         cmd_byte[7:4] == `SMSP_START_TEMP ||
                         cmd_byte[7:4] == `SMSP_START_CELL_DIS ||
                         cmd_byte[7:4] == `SMSP_START_OPEN_DIS) begin
              n.start    = 1'b1;
              n.poll_int = 1'b0;
              n.state    = smsp_pkg::DEV_POLL;
            end
          end
        end
      end
      smsp_pkg::DEV_WRITE: begin
        // Our 48 bits act as one stage of the chain shift register
        if (sclk_rise) begin
          n.wr_sh = {r.wr_sh[`SMSP_CFG_BITS-2:0], r.mosi_sy[1]};
          if (r.wr_cnt != 6'(`SMSP_CFG_BITS)) begin
            n.wr_cnt = r.wr_cnt + 6'h01;
          end
        end
        if (sclk_fall) begin
          n.hs_bit = r.wr_sh[`SMSP_CFG_BITS-1];
        end
      end
      smsp_pkg::DEV_READ: begin
        if (sclk_fall) begin
          n.low_bit = r.rd_sh[`SMSP_READ_BITS-1];
        end
        // Higher device data queues behind our group and error byte
        if (sclk_rise) begin
          n.rd_sh = {r.rd_sh[`SMSP_READ_BITS-2:0], r.hs_sy[1]};
        end
      end
      smsp_pkg::DEV_POLL: begin
        n.low_bit = poll_val;
      end
      smsp_pkg::DEV_MONITOR: begin
        n.low_bit = i_cell_alarm ? 1'b0 : r.tog;
      end
    endcase
    // Select rising ends any sequence; only a full write group is committed
    if (cs_rise && r.state != smsp_pkg::DEV_MONITOR) begin
      if (r.state == smsp_pkg::DEV_WRITE && r.wr_cnt == 6'(`SMSP_CFG_BITS)) begin
        n.cfg = r.wr_sh;
      end
      n.state = smsp_pkg::DEV_IDLE;
    end
    // Monitor mode overrides the serial interface entirely
    if (mm_low) begin
      n.cfg     = `SMSP_CFG_DEFAULT;
      n.state   = smsp_pkg::DEV_MONITOR;
      n.low_bit = i_cell_alarm ? 1'b0 : r.tog;
    end else if (mm_rise) begin
      n.cfg   = `SMSP_CFG_DEFAULT;
      n.state = smsp_pkg::DEV_IDLE;
    end
  end

  // State register
  always_ff @(posedge i_ref_clk) begin
    if (!i_nrst) begin
      r          <= '0;
      r.state    <= smsp_pkg::DEV_IDLE;
      r.sclk_sy  <= 3'h7;
      r.cs_sy    <= 3'h7;
      r.strap_s1 <= 3'h4;
      r.strap_s2 <= 3'h4;
      r.mm_prev  <= 1'b1;
      r.cfg      <= `SMSP_CFG_DEFAULT;
      r.low_bit  <= 1'b1;
      r.hs_bit   <= 1'b1;
      r.cs_out   <= 1'b1;
      r.sclk_out <= 1'b1;
    end else begin
      r <= n;
    end
  end

  // Data pins: bottom device answers on the open drain, others on the data pin
  assign drive_low               = r.state inside {smsp_pkg::DEV_READ, smsp_pkg::DEV_POLL,
                                                   smsp_pkg::DEV_MONITOR};
  assign link.bottom_data_out    = 1'b0;
  assign link.bottom_data_out_oe = bottom & drive_low & ~r.low_bit;
  assign link.lsd_o              = r.low_bit;
  assign link.lsd_oe             = ~bottom & drive_low;
  assign o_high_side_data        = r.hs_bit;
  assign o_high_side_data_oe     = ~drive_low;
  assign o_chip_select_out_n     = r.cs_out;
  assign o_serial_clock_out      = r.sclk_out;
  assign o_start_conv            = r.start;

  // Effective settings; monitor mode substitutes fixed values
  assign o_cfg                    = r.cfg;
  assign o_comparator_duty_cycle  = mm_low ? `SMSP_CDC_MONITOR :
                                    r.cfg[`SMSP_CFG_CDC_MSB:`SMSP_CFG_CDC_LSB];
  assign o_undervoltage_threshold = mm_low ? `SMSP_FACTORY_UV :
                                    r.cfg[`SMSP_CFG_UV_MSB:`SMSP_CFG_UV_LSB];
  assign o_overvoltage_threshold  = mm_low ? `SMSP_FACTORY_OV :
                                    r.cfg[`SMSP_CFG_OV_MSB:`SMSP_CFG_OV_LSB];
  assign o_level_poll_select      = level_sel;
  assign o_cell_count             = `SMSP_BASE_CELLS + {1'b0, r.pin_s2};
  assign o_monitor_mode           = mm_low;
  assign o_current_mode           = ~bottom;

endmodule

// File: smsp_link_props.sv
module smsp_link_props (
  // Clock and reset
  input wire logic i_ref_clk,
  input wire logic i_nrst,
  // Link signals between the two ends
  input wire logic chip_select_in_n,
  input wire logic serial_clock_in,
  input wire logic low_side_data,
  input wire logic lsd_o,
  input wire logic lsd_oe,
  input wire logic bottom_data_out,
  input wire logic bottom_data_out_oe,
  input wire logic miso
);
  timeunit 1ns;
  timeprecision 1ns;

  logic       sclk_q;
  logic [7:0] rise_cnt;

  // Rising clock edges in the current frame, cleared while deselected
  always_ff @(posedge i_ref_clk) begin
    sclk_q <= serial_clock_in;
    if (!i_nrst || chip_select_in_n) begin
      rise_cnt <= 8'h00;
    end else if (serial_clock_in && !sclk_q) begin
      rise_cnt <= rise_cnt + 8'h01;
    end
  end

  default clocking @(posedge i_ref_clk); endclocking
  default disable iff (!i_nrst);

  a_idle_clock_high: assert property (chip_select_in_n |-> serial_clock_in)
    else $error("link clock not high while deselected");
  a_data_steady: assert property (
    $rose(serial_clock_in) |-> $stable(low_side_data) ##1 $stable(low_side_data) [*3])
    else $error("data moved around the sampling edge");
  a_low_phase: assert property (
    $fell(serial_clock_in) |-> !serial_clock_in [*4] ##1 serial_clock_in)
    else $error("clock low phase not four cycles");
  a_high_phase: assert property (
    $rose(serial_clock_in) && !chip_select_in_n |-> serial_clock_in [*4])
    else $error("clock high phase too short");
  a_whole_bytes: assert property ($rose(chip_select_in_n) |-> rise_cnt[2:0] == 3'h0)
    else $error("frame ended inside a byte");
  a_read_steady: assert property (
    $fell(serial_clock_in) && rise_cnt > 8'h08 |-> $past(miso) == $past(miso, 2))
    else $error("read data changed during high phase");
  a_open_drain: assert property (bottom_data_out_oe |-> !bottom_data_out)
    else $error("open drain output driven high");
  a_lsd_quiet: assert property (!lsd_oe)
    else $error("bottom device drove its data input pin");
  a_frame_lead: assert property (
    $fell(chip_select_in_n) |-> !chip_select_in_n throughout (##[1:8] !serial_clock_in))
    else $error("select not held low into first bit");
endmodule

// File: testbench.sv
`include "smsp_params.svh"

module testbench;
  timeunit 1ns;
  timeprecision 1ns;

  logic        ref_clk, nrst, wb_cyc, wb_stb, wb_we, wb_ack;
  logic        mm_n, busy, alarm, start, mon, lvl, prev;
  logic        cs_o, sck_o, hs_o, hs_oe, cur;
  logic [3:0]  wb_adr, cells;
  logic [31:0] wb_wdat, wb_rdat, q;
  logic [2:0]  pins, cdc;
  logic [7:0]  uv, ov;
  logic [47:0] cfg, dev_cfg;
  logic [7:0]  fam [5];
  int          n_fail, n_compared, n_start, cycles, k, edges;

  smsp_if link();

  smsp_host i_smsp_host (.i_ref_clk(ref_clk), .i_nrst(nrst), .i_wb_cyc(wb_cyc),
    .i_wb_stb(wb_stb), .i_wb_we(wb_we), .i_wb_adr(wb_adr), .i_wb_dat(wb_wdat),
    .i_wb_sel(4'hF), .o_wb_dat(wb_rdat), .o_wb_ack(wb_ack), .link(link));

  smsp_device #(.TOGGLE_HALF(5)) i_smsp_device (.i_ref_clk(ref_clk), .i_nrst(nrst),
    .link(link), .i_high_side_data(1'b1), .o_high_side_data(hs_o),
    .o_high_side_data_oe(hs_oe), .o_chip_select_out_n(cs_o), .o_serial_clock_out(sck_o),
    .i_monitor_mode_strap_n(mm_n),
    .i_voltage_signalling_strap(1'b1), .i_top_of_stack_strap(1'b1),
    .i_watchdog_pin_n(pins[2]), .i_gp_pin_two(pins[1]), .i_gp_pin_one(pins[0]),
    .i_conv_busy(busy), .i_cell_alarm(alarm), .o_start_conv(start), .o_cfg(dev_cfg),
    .o_comparator_duty_cycle(cdc), .o_undervoltage_threshold(uv),
    .o_overvoltage_threshold(ov), .o_level_poll_select(lvl), .o_cell_count(cells),
    .o_monitor_mode(mon), .o_current_mode(cur));

  smsp_link_props i_smsp_link_props (.i_ref_clk(ref_clk), .i_nrst(nrst),
    .chip_select_in_n(link.chip_select_in_n), .serial_clock_in(link.serial_clock_in),
    .low_side_data(link.low_side_data), .lsd_o(link.lsd_o), .lsd_oe(link.lsd_oe),
    .bottom_data_out(link.bottom_data_out), .bottom_data_out_oe(link.bottom_data_out_oe),
    .miso(link.miso));

  // Reference clock
  initial ref_clk = 1'b0;
  always #50 ref_clk = ~ref_clk;

  // Start pulse count and hang guard
  always @(posedge ref_clk) begin
    cycles++;
    if (start === 1'b1) n_start++;
    if (cycles == 20000) begin
      n_fail++;
      print_verdict();
    end
  end

  task automatic print_verdict();
    $display("comparisons %0d, mismatches %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask

  task automatic check(input logic [47:0] seen, input logic [47:0] exp);
    n_compared++;
    if (seen !== exp) begin
      n_fail++;
      $display("mismatch at %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask

  // One classic cycle; only ack ends the wait, the hang guard covers a dead slave
  task automatic wb(input logic we, input logic [3:0] a, input logic [31:0] d);
    wb_cyc <= 1'b1;
    wb_stb <= 1'b1;
    wb_we <= we;
    wb_adr <= a;
    wb_wdat <= d;
    do begin
      @(posedge ref_clk);
    end while (wb_ack !== 1'b1);
    q = wb_rdat;
    wb_cyc <= 1'b0;
    wb_stb <= 1'b0;
    @(posedge ref_clk);
  endtask

  // Byte over the link, then wait until the port is free
  task automatic send(input logic [7:0] b, input logic keep);
    wb(1'b1, `SMSP_REG_XFER, {23'h0, keep, b});
    do begin
      wb(1'b0, `SMSP_REG_STATUS, 32'h0);
    end while (q[0] !== 1'b0);
  endtask

  // Poll state seen through the synchronised read line
  task automatic status(input logic exp);
    repeat (6) @(posedge ref_clk);
    wb(1'b0, `SMSP_REG_STATUS, 32'h0);
    check(q[2], exp);
  endtask

  // Error byte, most significant bit first over the whole group
  function automatic logic [7:0] crc8(input logic [47:0] d);
    logic [7:0] c;
    c = 8'h00;
    for (int i = 47; i >= 0; i--) c = {c[6:0], 1'b0} ^ ((c[7] ^ d[i]) ? 8'h07 : 8'h00);
    return c;
  endfunction

  initial begin
    nrst = 1'b0;
    wb_cyc = 1'b0;
    wb_stb = 1'b0;
    wb_we = 1'b0;
    wb_adr = 4'h0;
    wb_wdat = 32'h0000_0000;
    mm_n = 1'b1;
    pins = 3'h0;
    busy = 1'b0;
    alarm = 1'b0;
    cfg = 48'h13A5_C33C_5A7E;
    fam = '{8'h10, 8'h21, 8'h3E, 8'h60, 8'h7F};
    repeat (20) @(posedge ref_clk);
    nrst <= 1'b1;
    repeat (6) @(posedge ref_clk);
    check({cs_o, sck_o, hs_oe}, 3'b111);
    // Short write must not commit, full one commits at select rise
    send(`SMSP_CMD_WRITE_CFG, 1'b1);
    for (k = 0; k < 3; k++) send(cfg[47-8*k -: 8], k < 2);
    repeat (8) @(posedge ref_clk);
    check(dev_cfg, `SMSP_CFG_DEFAULT);
    send(`SMSP_CMD_WRITE_CFG, 1'b1);
    for (k = 0; k < 6; k++) send(cfg[47-8*k -: 8], k < 5);
    repeat (8) @(posedge ref_clk);
    check(dev_cfg, cfg);
    check({lvl, cdc, uv, ov}, {cfg[44], cfg[42:40], cfg[15:0]});
    // Group read back, then its error byte
    send(`SMSP_CMD_READ_CFG, 1'b1);
    for (k = 0; k < 7; k++) begin
      send(8'hFF, k < 6);
      wb(1'b0, `SMSP_REG_RXDATA, 32'h0);
      check(q[7:0], k < 6 ? cfg[47-8*k -: 8] : crc8(cfg));
    end
    // Level polling of both sources; extra clocks must not disturb it
    for (k = 0; k < 2; k++) begin
      busy <= (k == 0);
      alarm <= (k == 1);
      send(k == 0 ? `SMSP_CMD_POLL_CONV : `SMSP_CMD_POLL_INT, 1'b1);
      status(1'b0);
      check({cs_o, sck_o, hs_oe, cur}, 4'b0100);
      busy <= 1'b0;
      alarm <= 1'b0;
      status(1'b1);
      send(`SMSP_CMD_READ_CFG, 1'b1);
      status(1'b1);
      wb(1'b1, `SMSP_REG_RELEASE, 32'h0);
    end
    // Every start family gives exactly one pulse
    for (k = 0; k < 5; k++) begin
      send(fam[k], 1'b1);
      repeat (4) @(posedge ref_clk);
      check(hs_o, fam[k][0]);
      wb(1'b1, `SMSP_REG_RELEASE, 32'h0);
    end
    check(n_start, 5);
    // Standalone mode: fixed limits, pin-selected cell count
    mm_n <= 1'b0;
    repeat (8) @(posedge ref_clk);
    check({mon, cdc, uv, ov}, {1'b1, `SMSP_CDC_MONITOR, `SMSP_FACTORY_UV, `SMSP_FACTORY_OV});
    check(dev_cfg, `SMSP_CFG_DEFAULT);
    for (k = 0; k < 8; k++) begin
      pins <= k[2:0];
      repeat (8) @(posedge ref_clk);
      check(cells, 4'h5 + k[3:0]);
    end
    // Toggle runs with select high; half period of five cycles
    edges = 0;
    prev = link.miso;
    for (k = 0; k < 40; k++) begin
      @(posedge ref_clk);
      edges += (link.miso !== prev);
      prev = link.miso;
    end
    check(edges inside {[7:9]}, 1'b1);
    alarm <= 1'b1;
    repeat (8) @(posedge ref_clk);
    check(link.miso, 1'b0);
    alarm <= 1'b0;
    mm_n <= 1'b1;
    repeat (8) @(posedge ref_clk);
    check({mon, cdc, uv, ov}, 20'h0_0000);
    check(dev_cfg, `SMSP_CFG_DEFAULT);
    print_verdict();
  end
endmodule
